// File: src/alu_defs.svh
// What this block does
// - immediate sum into accumulator, flags updated
// - register sum with accumulator, flags updated
// - target bit 0 accumulator, 1 register
// - immediate mask into accumulator, null only
// - register mask routed by target, null only
// - clear selected register bit, flags kept
// - set selected register bit, flags kept
// - tested bit one: next instruction runs
// - tested bit zero: next becomes no-operation
// - successful test costs second no-op cycle
// - port read-modify-write uses pin levels
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// -------------------------------------------------------------
// instruction word fields
// -------------------------------------------------------------
`define INSTR_W        14
`define CLASS_HI       13
`define CLASS_LO       12
`define SUB_HI         11
`define SUB_LO         8
`define TARGET_BIT     7
`define FADDR_HI       6
`define BITPOS_HI      9
`define BITPOS_LO      7
`define CLASS_BYTE     2'h0
`define CLASS_BIT      2'h1
`define CLASS_LIT      2'h3
`define SUB_ADD_REG    4'h7
`define SUB_AND_REG    4'h5
`define SUB_AND_LIT    4'h9
`define SUB_ADD_LIT    3'h7
`define BSUB_CLR       2'h0
`define BSUB_SET       2'h1
`define BSUB_TST       2'h2

// -------------------------------------------------------------
// register port map and reset values
// -------------------------------------------------------------
`define MEM_DEPTH      128
`define ADDR_W         8
`define ADDR_ACCUM     8'h80
`define ADDR_FLAGS     8'h81
`define PORT_ADDR_DEF  7'h06
`define ACCUM_RST      8'h00
`define MEM_RST        8'h00

`endif

// File: src/alu_pkg.sv
package alu_pkg;
  `include "alu_defs.svh"

  typedef enum
  {
    OP_NONE,
    OP_ADD_LIT,
    OP_ADD_REG,
    OP_AND_LIT,
    OP_AND_REG,
    OP_BIT_CLR,
    OP_BIT_SET,
    OP_BIT_TST
  } op_t;

  typedef logic [7:0] byte_t;

  typedef struct packed
  {
    logic [`MEM_DEPTH-1:0][7:0] mem;
    byte_t                      accum;
    logic                       flag_c;
    logic                       flag_dc;
    logic                       flag_z;
    logic                       squash;
    byte_t                      rdata;
  } state_t;
endpackage

// File: src/accum_logic_bit_ops.sv
`timescale 1ns/10ps
`include "alu_defs.svh"

module accum_logic_bit_ops
#(
  parameter logic [6:0] PORT_ADDR = `PORT_ADDR_DEF
)
(
  input  wire logic                   CLOCK,
  input  wire logic                   SYS_RST,
  input  wire logic                   INSTR_VALID,
  input  wire logic [`INSTR_W-1:0]    INSTR,
  input  wire alu_pkg::byte_t         PORT_PINS,
  input  wire logic [`ADDR_W-1:0]     REG_ADDR,
  input  wire alu_pkg::byte_t         REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output alu_pkg::byte_t              REG_RDATA,
  output alu_pkg::byte_t              ACCUM,
  output logic                        CARRY_FLAG,
  output logic                        NIBBLE_FLAG,
  output logic                        NULL_FLAG,
  output logic                        SQUASH_NEXT,
  output alu_pkg::byte_t              PORT_LATCH
);
  import alu_pkg::*;

  // the port must fall inside data memory, or its pins would never be read
  if (int'(PORT_ADDR) >= `MEM_DEPTH)
  begin : g_bad_port
    $error("port address outside data memory");
  end

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic op_t decode(input logic [`INSTR_W-1:0] w);
    logic [1:0] cls;
    logic [3:0] sub;
    op_t        op;
    cls = w[`CLASS_HI:`CLASS_LO];
    sub = w[`SUB_HI:`SUB_LO];
    op  = OP_NONE;
    unique case (cls)
      `CLASS_BYTE:
      begin
        if (sub == `SUB_ADD_REG)
          op = OP_ADD_REG;
        else if (sub == `SUB_AND_REG)
          op = OP_AND_REG;
      end
      `CLASS_BIT:
      begin
        unique case (sub[3:2])
          `BSUB_CLR: op = OP_BIT_CLR;
          `BSUB_SET: op = OP_BIT_SET;
          `BSUB_TST: op = OP_BIT_TST;
          default:   op = OP_NONE;
        endcase
      end
      `CLASS_LIT:
      begin
        if (sub[3:1] == `SUB_ADD_LIT)
          op = OP_ADD_LIT;
        else if (sub == `SUB_AND_LIT)
          op = OP_AND_LIT;
      end
      default: op = OP_NONE;
    endcase
    return op;
  endfunction

  // returns {carry out of bit 7, carry out of bit 3, 8-bit sum}
  function automatic logic [9:0] add8(input byte_t a, input byte_t b);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  state_t     s_q;
  state_t     s_d;
  op_t        op;
  logic [6:0] faddr;
  logic [2:0] bpos;
  byte_t      lit;
  byte_t      operand;
  byte_t      result;
  logic [9:0] sum;
  logic       to_reg;
  logic       exec;

  always_comb
  begin
    s_d     = s_q;
    op      = decode(INSTR);
    faddr   = INSTR[`FADDR_HI:0];
    bpos    = INSTR[`BITPOS_HI:`BITPOS_LO];
    lit     = INSTR[7:0];
    to_reg  = INSTR[`TARGET_BIT];
    // the port reads back the pins, not the latch, so an input held
    // low by the outside is written back low
    operand = (faddr == PORT_ADDR) ? PORT_PINS : s_q.mem[faddr];
    sum     = 10'h000;
    result  = 8'h00;
    exec    = INSTR_VALID && !s_q.squash;

    // bus access first; a core write to the same cell overrides it
    if (REG_WR)
    begin
      if (!REG_ADDR[7])
        s_d.mem[REG_ADDR[6:0]] = REG_WDATA;
      else if (REG_ADDR == `ADDR_ACCUM)
        s_d.accum = REG_WDATA;
      else if (REG_ADDR == `ADDR_FLAGS)
        {s_d.flag_z, s_d.flag_dc, s_d.flag_c} = REG_WDATA[2:0];
    end
    s_d.rdata = 8'h00;
    if (REG_RD)
    begin
      if (!REG_ADDR[7])
        s_d.rdata = s_q.mem[REG_ADDR[6:0]];
      else if (REG_ADDR == `ADDR_ACCUM)
        s_d.rdata = s_q.accum;
      else if (REG_ADDR == `ADDR_FLAGS)
        s_d.rdata = {5'h00, s_q.flag_z, s_q.flag_dc, s_q.flag_c};
    end

    // a squashed slot runs as a no-operation and clears the squash
    if (INSTR_VALID && s_q.squash)
      s_d.squash = 1'b0;

    if (exec)
    begin
      unique case (op)
        OP_ADD_LIT:
        begin
          sum       = add8(s_q.accum, lit);
          s_d.accum = sum[7:0];
          s_d.flag_c  = sum[9];
          s_d.flag_dc = sum[8];
          s_d.flag_z  = (sum[7:0] == 8'h00);
        end
        OP_ADD_REG:
        begin
          sum = add8(s_q.accum, operand);
          if (to_reg)
            s_d.mem[faddr] = sum[7:0];
          else
            s_d.accum = sum[7:0];
          s_d.flag_c  = sum[9];
          s_d.flag_dc = sum[8];
          s_d.flag_z  = (sum[7:0] == 8'h00);
        end
        OP_AND_LIT:
        begin
          result     = s_q.accum & lit;
          s_d.accum  = result;
          s_d.flag_z = (result == 8'h00);
        end
        OP_AND_REG:
        begin
          result = s_q.accum & operand;
          if (to_reg)
            s_d.mem[faddr] = result;
          else
            s_d.accum = result;
          s_d.flag_z = (result == 8'h00);
        end
        OP_BIT_CLR:
        begin
          result         = operand;
          result[bpos]   = 1'b0;
          s_d.mem[faddr] = result;
        end
        OP_BIT_SET:
        begin
          result         = operand;
          result[bpos]   = 1'b1;
          s_d.mem[faddr] = result;
        end
        OP_BIT_TST:
        begin
          // bit one: next instruction runs; bit zero: it is discarded
          s_d.squash = !operand[bpos];
        end
        OP_NONE:
        begin
          s_d.squash = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      s_q.mem     <= {`MEM_DEPTH{`MEM_RST}};
      s_q.accum   <= `ACCUM_RST;
      s_q.flag_c  <= 1'b0;
      s_q.flag_dc <= 1'b0;
      s_q.flag_z  <= 1'b0;
      s_q.squash  <= 1'b0;
      s_q.rdata   <= 8'h00;
    end
    else
      s_q <= s_d;
  end

  // -------------------------------------------------------------
  // outputs, all straight from flops
  // -------------------------------------------------------------
  assign REG_RDATA   = s_q.rdata;
  assign ACCUM       = s_q.accum;
  assign CARRY_FLAG  = s_q.flag_c;
  assign NIBBLE_FLAG = s_q.flag_dc;
  assign NULL_FLAG   = s_q.flag_z;
  assign SQUASH_NEXT = s_q.squash;
  assign PORT_LATCH  = s_q.mem[PORT_ADDR];

endmodule

// File: tb/alu_chk_assertions.sv
`timescale 1ns/10ps
// ------------------
// accumulator, flag, port and skip checks
// ------------------
module alu_chk
#(
  parameter logic [6:0] PORT_ADDR = 7'h06
)
(
  input wire logic           CLOCK,
  input wire logic           SYS_RST,
  input wire logic           INSTR_VALID,
  input wire logic [13:0]    INSTR,
  input wire alu_pkg::byte_t PORT_PINS,
  input wire alu_pkg::byte_t ACCUM,
  input wire logic           CARRY_FLAG,
  input wire logic           NIBBLE_FLAG,
  input wire logic           NULL_FLAG,
  input wire logic           SQUASH_NEXT,
  input wire alu_pkg::byte_t PORT_LATCH
);
  import alu_pkg::*;
  wire logic       go   = INSTR_VALID && !SQUASH_NEXT;
  wire logic       adl  = go && INSTR[13:9] == 5'h1F;
  wire logic       anl  = go && INSTR[13:8] == 6'h39;
  wire logic       bop  = go && INSTR[13:12] == 2'h1 && INSTR[11:10] != 2'h3;
  wire logic       tst  = go && INSTR[13:10] == 4'h6;
  wire logic       onp  = INSTR[6:0] == PORT_ADDR;
  wire logic       pbit = PORT_PINS[INSTR[9:7]];
  wire logic [8:0] ksum = ACCUM + INSTR[7:0] + 9'h000;
  wire logic [4:0] nsum = ACCUM[3:0] + INSTR[3:0] + 5'h00;
  wire byte_t      pset = PORT_PINS | (8'h01 << INSTR[9:7]);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_drop;
    INSTR_VALID && SQUASH_NEXT;
  endsequence
  a_add_sum: assert property (adl |=> {CARRY_FLAG, ACCUM} == $past(ksum))
    else $error("sum or carry wrong");
  a_add_nibble: assert property (adl |=> NIBBLE_FLAG == $past(nsum[4]))
    else $error("nibble flag wrong");
  a_null_track: assert property (adl || anl |=> NULL_FLAG == (ACCUM == 8'h00))
    else $error("null flag wrong");
  a_mask_only: assert property (anl |=> $stable({CARRY_FLAG, NIBBLE_FLAG}))
    else $error("mask touched carries");
  a_bit_flags: assert property (bop |=> $stable({CARRY_FLAG, NIBBLE_FLAG, NULL_FLAG}))
    else $error("bit op touched flags");
  a_port_set: assert property (bop && onp && INSTR[11:10] == 2'h1 |=> PORT_LATCH == $past(pset))
    else $error("port set not from pins");
  a_skip_decide: assert property (tst && onp |=> SQUASH_NEXT == !$past(pbit))
    else $error("skip decision wrong");
  a_drop_slot: assert property (s_drop |=> !SQUASH_NEXT && $stable(ACCUM))
    else $error("squashed slot acted");
  a_squash_cause: assert property ($rose(SQUASH_NEXT) |-> $past(tst))
    else $error("squash without test");
endmodule

bind accum_logic_bit_ops alu_chk #(.PORT_ADDR(PORT_ADDR)) u_alu_chk (.*);

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import alu_pkg::*;
  logic         CLOCK = 1'b0;
  logic         SYS_RST = 1'b1;
  logic         INSTR_VALID = 1'b0;
  logic [13:0]  INSTR = 14'h0000;
  byte_t        PORT_PINS = 8'hA5;
  logic [7:0]   REG_ADDR = 8'h00;
  byte_t        REG_WDATA = 8'h00;
  logic         REG_WR = 1'b0;
  logic         REG_RD = 1'b0;
  byte_t        REG_RDATA, ACCUM, PORT_LATCH, e, pat;
  logic         CARRY_FLAG, NIBBLE_FLAG, NULL_FLAG, SQUASH_NEXT;
  int           err_total = 0;
  int           num_checks = 0;
  wire byte_t   flg = {5'h00, NULL_FLAG, NIBBLE_FLAG, CARRY_FLAG};

  accum_logic_bit_ops u_accum_logic_bit_ops (.*);
  always #25 CLOCK = ~CLOCK;

  // ------------------
  // access tasks
  // ------------------
  task chk(input byte_t g, input byte_t x);
    num_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // ex, wr and rd each drop their strobe then step 1 ns, so back-to-back calls never clash
  task ex(input logic [13:0] i);
    INSTR_VALID <= 1'b1;
    INSTR <= i;
    @(posedge CLOCK);
    INSTR_VALID <= 1'b0;
    #1;
  endtask
  task wr(input logic [7:0] a, input byte_t d);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input byte_t x);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, x);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    final_report;
  end

  // ------------------
  // tests
  // ------------------
  initial
  begin
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    @(posedge CLOCK);
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    wr(8'h90, 8'h5A);
    rd(8'h90, 8'h00);
    $display("test bus done");
    ex({6'h3E, 8'hF8});
    ex({6'h3F, 8'h18});
    chk(ACCUM, 8'h10);
    chk(flg, 8'h03);
    ex({6'h39, 8'h30});
    chk(flg, 8'h03);
    ex({6'h39, 8'h0F});
    chk(ACCUM, 8'h00);
    chk(flg, 8'h07);
    $display("test literal done");
    wr(8'h20, 8'h9C);
    ex({6'h3E, 8'h71});
    ex({6'h07, 1'b0, 7'h20});
    chk(ACCUM, 8'h0D);
    chk(flg, 8'h01);
    ex({6'h07, 1'b1, 7'h20});
    rd(8'h20, 8'hA9);
    chk(flg, 8'h02);
    ex({6'h05, 1'b1, 7'h20});
    rd(8'h20, 8'h09);
    ex({6'h05, 1'b0, 7'h20});
    chk(ACCUM, 8'h09);
    $display("test register done");
    e = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      ex({3'h2, i < 8, i[2:0], 7'h30});
      e = (i < 8) ? e | (8'h01 << i[2:0]) : e & ~(8'h01 << i[2:0]);
      rd(8'h30, e);
    end
    chk(flg, 8'h02);
    ex({4'h5, 3'h1, 7'h06});
    chk(PORT_LATCH, 8'hA7);
    ex({4'h6, 3'h1, 7'h06});
    chk({7'h00, SQUASH_NEXT}, 8'h01);
    ex({6'h3E, 8'h01});
    chk(ACCUM, 8'h09);
    $display("test bits done");
    pat = 8'h5A;
    wr(8'h30, pat);
    e = ACCUM;
    for (int i = 0; i < 8; i++)
    begin
      ex({4'h6, i[2:0], 7'h30});
      chk({7'h00, SQUASH_NEXT}, {7'h00, ~pat[i]});
      ex({6'h3E, 8'h01});
      e = e + {7'h00, pat[i]};
      chk(ACCUM, e);
    end
    $display("test skip done");
    final_report;
  end
endmodule
